// >>> src/dtc_ctrl.v
// debug trace control register and the side effects of its bits
// assumes core pipeline supplies one-cycle event pulses on CLK
`timescale 1ns/10ps
`include "dtc_consts.vh"
module dtc_ctrl
(
    input  wire        CLK,
    input  wire        RST_N,
    input  wire        REG_WR,
    input  wire        REG_RD,
    input  wire [11:0] REG_ADDR,
    input  wire [63:0] REG_WDATA,
    output reg  [63:0] REG_RDATA,
    output reg         REG_HIT,
    input  wire        BR_TAKEN,
    input  wire        IRQ_TAKEN,
    input  wire        EXC_TAKEN,
    input  wire        EXC_IS_DEBUG,
    input  wire [63:0] BR_REC,
    input  wire [1:0]  PRIV_LEVEL,
    input  wire        STEP_FLAG,
    input  wire        INSTR_DONE,
    input  wire        BUSLOCK_SEEN,
    input  wire        IN_TX,
    input  wire        DBG_EVENT,
    input  wire        BP_EVENT,
    input  wire        BPCTL_TXDBG,
    input  wire [63:0] TX_BEGIN_PC,
    input  wire [63:0] TX_FALLBACK_PC,
    input  wire        TX_CONFLICT,
    input  wire        PERF_IRQ,
    input  wire        MGMT_IRQ,
    input  wire        MGMT_RETURN,
    input  wire        SCHED_HINT_EN,
    input  wire        BUF_FULL,
    input  wire [2:0]  HIST_IDX,
    output reg  [63:0] HIST_DATA,
    output reg         TX_ABORT,
    output reg  [63:0] TX_RESUME_PC,
    output reg  [31:0] ABORT_STATUS,
    output reg         DBG_EXC,
    output reg         DSTAT_TXDBG,
    output reg         STEP_TRAP,
    output reg         BUSLOCK_EXC,
    output reg         TRACE_MSG,
    output reg  [63:0] TRACE_MSG_DATA,
    output reg         TRACE_STORE,
    output reg         TRACE_WRAP,
    output reg         TRACE_BUF_IRQ,
    output reg         HIST_FROZEN,
    output reg         CNT_FROZEN,
    output reg  [7:0]  CNT_GLOBAL_EN,
    output reg         SCHED_HIST_RST,
    output reg  [63:0] PERF_CAP
);
    reg  [63:0] ctl_r;
    reg  [63:0] ctl_nxt;
    reg  [63:0] save_r;
    reg         hfrz_r;
    wire [63:0] hist_rd;
    reg  [1:0]  mst_r;
    reg  [1:0]  mst_nxt;
    wire        mgmt_save;
    wire        mgmt_ret_ok;
    wire        step_hit;
    wire        ev_any;
    wire        ev_rec;
    wire        priv0;
    wire        trace_ok;
    wire        tx_dbg_hit;
    wire        adv_dbg;
    wire        fire_dbg;
    wire        ctl_sel;

    // management tracker, one-hot: running, or inside with a saved copy
    localparam [1:0] MST_RUN   = 2'b01;
    localparam [1:0] MST_SAVED = 2'b10;

    assign priv0    = (PRIV_LEVEL == 2'h0);
    assign ctl_sel  = (REG_ADDR == `DTC_REG_ADDR);
    assign mgmt_save   = MGMT_IRQ & ctl_r[`DTC_BIT_MGMTFRZ];
    // a return with no saved copy must not clobber the control word
    assign mgmt_ret_ok = MGMT_RETURN & (mst_r == MST_SAVED);
    assign ev_any   = BR_TAKEN | IRQ_TAKEN | EXC_TAKEN;
    // debug exceptions excluded from branch history
    assign ev_rec   = BR_TAKEN | IRQ_TAKEN
                    | (EXC_TAKEN & ~EXC_IS_DEBUG);
    assign trace_ok = ~((priv0 & ctl_r[`DTC_BIT_SKIPPRIV])
                    | (~priv0 & ctl_r[`DTC_BIT_SKIPUSER]));
    assign tx_dbg_hit = IN_TX & (DBG_EVENT | BP_EVENT);
    assign adv_dbg  = BPCTL_TXDBG & ctl_r[`DTC_BIT_TXDBG];
    // step trap only when stepping, on branches under branch-step mode
    // one step decode shared by the trap pulse and the control clear
    assign step_hit = STEP_FLAG & INSTR_DONE
                    & (~ctl_r[`DTC_BIT_BRSTEP] | BR_TAKEN);
    assign fire_dbg = (tx_dbg_hit & adv_dbg)
                    | (DBG_EVENT & ~IN_TX)
                    | step_hit;

    // history update: recording on, no freeze; trace-msg also feeds it
    dtc_hist u_hist
    (
        .CLK     (CLK),
        .RST_N   (RST_N),
        .push    (ev_rec & ~hfrz_r
                  & (ctl_r[`DTC_BIT_BRREC]
                     | ctl_r[`DTC_BIT_TRMSG])),
        .rec     (BR_REC),
        .rd_idx  (HIST_IDX),
        .rd_data (hist_rd),
        .top_r   ()
    );

    always @*
    begin
        ctl_nxt = ctl_r;
        if (REG_WR && ctl_sel)
            ctl_nxt = REG_WDATA & `DTC_WMASK;
        // hardware events win over a simultaneous software write
        if (fire_dbg)
        begin
            ctl_nxt[`DTC_BIT_BRREC]  = 1'b0;
            ctl_nxt[`DTC_BIT_BRSTEP] = 1'b0;
        end
        if (MGMT_IRQ && ctl_r[`DTC_BIT_MGMTFRZ])
        begin
            ctl_nxt[`DTC_BIT_BRREC]   = 1'b0;
            ctl_nxt[`DTC_BIT_BRSTEP]  = 1'b0;
            ctl_nxt[`DTC_BIT_TRMSG]   = 1'b0;
            ctl_nxt[`DTC_BIT_TRSTORE] = 1'b0;
        end
        // the restore is last so it wins over every other update
        if (mgmt_ret_ok)
            ctl_nxt = save_r;
    end

    // tracks whether a saved copy is pending a return
    // a second entry while saved keeps the first copy intact
    always @*
    begin
        mst_nxt = mst_r;
        case (mst_r)
            MST_RUN:
            begin
                // only an entry with the freeze bit saves a copy
                if (mgmt_save)
                    mst_nxt = MST_SAVED;
            end
            MST_SAVED:
            begin
                if (MGMT_RETURN)
                    mst_nxt = MST_RUN;
            end
            default:
                mst_nxt = MST_RUN;
        endcase
    end

    always @(posedge CLK)
    begin
        if (!RST_N)
            mst_r <= MST_RUN;
        else
            mst_r <= mst_nxt;
    end

    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ctl_r          <= `DTC_RESET_VAL;
            save_r         <= `DTC_RESET_VAL;
            REG_RDATA      <= 64'h0;
            REG_HIT        <= 1'b0;
            HIST_DATA      <= 64'h0;
            PERF_CAP       <= 64'h0;
        end
        else
        begin
            ctl_r     <= ctl_nxt;
            HIST_DATA <= hist_rd;
            REG_HIT   <= (REG_RD | REG_WR) & ctl_sel;
            REG_RDATA <= (REG_RD && ctl_sel) ? ctl_r : 64'h0;
            PERF_CAP  <= 64'h1 << `DTC_CAP_MGMTFRZ;
            if (mgmt_save && mst_r == MST_RUN)
                save_r <= ctl_r;
        end
    end

    // perf-interrupt freezes; a set in the same cycle as a write
    // wins, so a freeze is never lost to a racing reprogram
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            hfrz_r      <= 1'b0;
            HIST_FROZEN <= 1'b0;
            CNT_FROZEN  <= 1'b0;
        end
        else
        begin
            // freeze holds until software rewrites the control word
            if (PERF_IRQ && ctl_r[`DTC_BIT_HFREEZE])
                hfrz_r <= 1'b1;
            else if (REG_WR && ctl_sel)
                hfrz_r <= 1'b0;
            HIST_FROZEN <= hfrz_r;
            if (PERF_IRQ && ctl_r[`DTC_BIT_CFREEZE])
                CNT_FROZEN <= 1'b1;
            else if (REG_WR && ctl_sel)
                CNT_FROZEN <= 1'b0;
        end
    end

    // global counter enables: cleared on a saving entry, set on return
    // scheduling-history reset pulses on both while hints are enabled
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            CNT_GLOBAL_EN  <= `DTC_CNT_EN_ONES;
            SCHED_HIST_RST <= 1'b0;
        end
        else
        begin
            if (mgmt_ret_ok)
                CNT_GLOBAL_EN <= `DTC_CNT_EN_ONES;
            else if (mgmt_save)
                CNT_GLOBAL_EN <= `DTC_CNT_EN_ZERO;
            SCHED_HIST_RST <= SCHED_HINT_EN & (MGMT_RETURN
                | (MGMT_IRQ & ctl_r[`DTC_BIT_MGMTFRZ]));
        end
    end

    // transaction aborts; status and resume point hold until the
    // next abort so the recovery code can read them at leisure
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            TX_ABORT     <= 1'b0;
            TX_RESUME_PC <= 64'h0;
            ABORT_STATUS <= 32'h0;
        end
        else
        begin
            // transaction abort and resume point
            TX_ABORT <= tx_dbg_hit | (IN_TX & TX_CONFLICT);
            if (tx_dbg_hit)
            begin
                ABORT_STATUS <= 32'h1 << `DTC_ABORT_DBG_BIT;
                TX_RESUME_PC <= adv_dbg ? TX_BEGIN_PC
                                        : TX_FALLBACK_PC;
            end
            else if (IN_TX && TX_CONFLICT)
            begin
                ABORT_STATUS <= 32'h0;
                TX_RESUME_PC <= TX_FALLBACK_PC;
            end
        end
    end

    // debug exception, step trap and bus-lock trap pulses
    // a debug event inside a transaction without adv debug is silent
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            DBG_EXC     <= 1'b0;
            DSTAT_TXDBG <= 1'b0;
            STEP_TRAP   <= 1'b0;
            BUSLOCK_EXC <= 1'b0;
        end
        else
        begin
            DBG_EXC     <= fire_dbg;
            if (fire_dbg)
                DSTAT_TXDBG <= ~(tx_dbg_hit & adv_dbg);
            STEP_TRAP <= step_hit;
            BUSLOCK_EXC <= BUSLOCK_SEEN & ctl_r[`DTC_BIT_BLD]
                         & ~priv0;
        end
    end

    // trace message and trace store strobes toward the bus unit
    // the buffer itself lives outside; only its full flag comes in
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            TRACE_MSG      <= 1'b0;
            TRACE_MSG_DATA <= 64'h0;
            TRACE_STORE    <= 1'b0;
            TRACE_WRAP     <= 1'b0;
            TRACE_BUF_IRQ  <= 1'b0;
        end
        else
        begin
            TRACE_MSG <= ev_any & ctl_r[`DTC_BIT_TRMSG]
                       & trace_ok;
            TRACE_MSG_DATA <= BR_REC;
            TRACE_STORE <= ev_any & ctl_r[`DTC_BIT_TRSTORE] & trace_ok
                & ~(BUF_FULL & ctl_r[`DTC_BIT_BUFIRQ]);
            TRACE_WRAP <= ev_any & ctl_r[`DTC_BIT_TRSTORE] & trace_ok
                & BUF_FULL & ~ctl_r[`DTC_BIT_BUFIRQ];
            TRACE_BUF_IRQ <= BUF_FULL & ctl_r[`DTC_BIT_TRSTORE]
                & ctl_r[`DTC_BIT_BUFIRQ];
        end
    end
endmodule // dtc_ctrl

// >>> src/dtc_consts.vh
// constants for the debug trace control block
// assumes inclusion by bare name from the design files
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH
`define DTC_REG_ADDR        12'h1D9
`define DTC_BIT_BRREC       0
`define DTC_BIT_BRSTEP      1
`define DTC_BIT_BLD         2
`define DTC_BIT_TRMSG       6
`define DTC_BIT_TRSTORE     7
`define DTC_BIT_BUFIRQ      8
`define DTC_BIT_SKIPPRIV    9
`define DTC_BIT_SKIPUSER    10
`define DTC_BIT_HFREEZE     11
`define DTC_BIT_CFREEZE     12
`define DTC_BIT_MGMTFRZ     14
`define DTC_BIT_TXDBG       15
`define DTC_WMASK           64'h000000000000DFC7
`define DTC_RESET_VAL       64'h0000000000000000
`define DTC_BPCTL_TXDBG     11
`define DTC_DSTAT_TXDBG     16
`define DTC_ABORT_DBG_BIT   4
`define DTC_CAP_MGMTFRZ     12
`define DTC_HIST_DEPTH      8
`define DTC_HIST_PTR_W      3
`define DTC_BUF_DEPTH       16
`define DTC_BUF_PTR_W       4
`define DTC_CNT_EN_ONES     8'hFF
`define DTC_CNT_EN_ZERO     8'h00
`endif

// >>> src/dtc_hist.v
// branch history stack: circular record of recent branch addresses
// assumes push is a one-cycle pulse on the core clock
`timescale 1ns/10ps
`include "dtc_consts.vh"
module dtc_hist
(
    input  wire                       CLK,
    input  wire                       RST_N,
    input  wire                       push,
    input  wire [63:0]                rec,
    input  wire [`DTC_HIST_PTR_W-1:0] rd_idx,
    output reg  [63:0]                rd_data,
    output reg  [`DTC_HIST_PTR_W-1:0] top_r
);
    reg [63:0] mem [0:`DTC_HIST_DEPTH-1];

    always @(posedge CLK)
    begin
        if (!RST_N)
            top_r <= {`DTC_HIST_PTR_W{1'b0}};
        else if (push)
        begin
            mem[top_r] <= rec;
            top_r      <= top_r + 1'b1;
        end
    end

    // entries are never cleared by reset; only the pointer is
    always @(posedge CLK)
    begin
        rd_data <= mem[rd_idx];
    end
endmodule // dtc_hist

// >>> tb/dtc_properties.sv
// assertion checker for the debug trace control register block
// assumes bind onto dtc_ctrl; one core clock, sync active-low reset
`timescale 1ns/10ps
module dtc_properties
(
    input wire        CLK,
    input wire        RST_N,
    input wire        REG_RD,
    input wire [11:0] REG_ADDR,
    input wire [63:0] REG_RDATA,
    input wire        REG_HIT,
    input wire [1:0]  PRIV_LEVEL,
    input wire        IN_TX,
    input wire        DBG_EVENT,
    input wire        BP_EVENT,
    input wire [63:0] TX_BEGIN_PC,
    input wire [63:0] TX_FALLBACK_PC,
    input wire        MGMT_RETURN,
    input wire        TX_ABORT,
    input wire [63:0] TX_RESUME_PC,
    input wire [31:0] ABORT_STATUS,
    input wire        DBG_EXC,
    input wire        DSTAT_TXDBG,
    input wire        BUSLOCK_EXC,
    input wire [7:0]  CNT_GLOBAL_EN,
    input wire [63:0] PERF_CAP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_tx_dbg;
        IN_TX && (DBG_EVENT || BP_EVENT);
    endsequence
    sequence s_rd_miss;
        REG_RD && (REG_ADDR != 12'h1D9);
    endsequence
    chk_tx_abort_stat: assert property (s_tx_dbg |=> TX_ABORT
        && ABORT_STATUS[4]) else $error("tx debug abort lost");
    chk_resume_begin: assert property (TX_ABORT && DBG_EXC |->
        TX_RESUME_PC == $past(TX_BEGIN_PC)) else $error("bad resume");
    chk_resume_fall: assert property (TX_ABORT && !DBG_EXC |->
        TX_RESUME_PC == $past(TX_FALLBACK_PC)) else $error("bad fallback");
    chk_dstat_clear: assert property (TX_ABORT && DBG_EXC |->
        !DSTAT_TXDBG) else $error("status bit16 set on tx debug");
    chk_addr_hit: assert property (REG_RD && REG_ADDR == 12'h1D9
        |=> REG_HIT) else $error("register not hit");
    chk_miss_zero: assert property (s_rd_miss |=>
        REG_RDATA == 64'h0 && !REG_HIT) else $error("unmapped read");
    chk_buslock_priv: assert property (BUSLOCK_EXC |->
        $past(PRIV_LEVEL) != 2'h0) else $error("bus lock at level 0");
    chk_cnt_restore: assert property (MGMT_RETURN |=>
        CNT_GLOBAL_EN == 8'hFF) else $error("enables not restored");
    chk_cap_bit: assert property (RST_N |=> PERF_CAP[12])
        else $error("capability bit missing");
endmodule // dtc_properties
bind dtc_ctrl dtc_properties u_props (.*);

// >>> tb/test_debug_trace_control_logic.sv
// self-checking bench for the debug trace control register block
// assumes dtc_ctrl with its bound checker; bench drives all events
`timescale 1ns/10ps
module test_debug_trace_control_logic;
    reg         CLK, RST_N, REG_WR, REG_RD, BR_TAKEN, IRQ_TAKEN;
    reg         EXC_TAKEN, EXC_IS_DEBUG, STEP_FLAG, INSTR_DONE, IN_TX;
    reg         BUSLOCK_SEEN, DBG_EVENT, BP_EVENT, BPCTL_TXDBG, BUF_FULL;
    reg         TX_CONFLICT, PERF_IRQ, MGMT_IRQ, MGMT_RETURN, SCHED_HINT_EN;
    reg  [11:0] REG_ADDR;
    reg  [63:0] REG_WDATA, BR_REC, TX_BEGIN_PC, TX_FALLBACK_PC, d;
    reg  [1:0]  PRIV_LEVEL;
    reg  [2:0]  HIST_IDX;
    wire [63:0] REG_RDATA, HIST_DATA, TX_RESUME_PC, TRACE_MSG_DATA, PERF_CAP;
    wire [31:0] ABORT_STATUS;
    wire [7:0]  CNT_GLOBAL_EN;
    wire        REG_HIT, TX_ABORT, DBG_EXC, DSTAT_TXDBG, STEP_TRAP;
    wire        BUSLOCK_EXC, TRACE_MSG, TRACE_STORE, TRACE_WRAP;
    wire        TRACE_BUF_IRQ, HIST_FROZEN, CNT_FROZEN, SCHED_HIST_RST;
    integer     bad_count = 0, checks = 0, seed = 32'h230656fe, i, k;
    reg  [63:0] exp_q[$];
    reg         rd_d = 1'b0;
    dtc_ctrl u_dut (.*);
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task automatic check(input [63:0] got, input [63:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("ERROR %0t: saw %h, wanted %h", $time, got, exp);
        end
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task wr(input [63:0] v);
    begin
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= 12'h1D9;
        REG_WDATA <= v;
        @(posedge CLK) REG_WR <= 1'b0;
    end
    endtask
    // expectation queued here, compared by the monitor below
    task rd(input [11:0] a, input [63:0] e);
    begin
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        exp_q.push_back(e);
        @(posedge CLK) REG_RD <= 1'b0;
    end
    endtask
    always @(posedge CLK) rd_d <= REG_RD;
    always @(negedge CLK)
        if (rd_d)
            check(REG_RDATA, exp_q.pop_front());
    initial
    begin
        {REG_WR, REG_RD, BR_TAKEN, IRQ_TAKEN, EXC_TAKEN, EXC_IS_DEBUG,
         STEP_FLAG, INSTR_DONE, IN_TX, BUSLOCK_SEEN, DBG_EVENT, BP_EVENT,
         BPCTL_TXDBG, BUF_FULL, TX_CONFLICT, PERF_IRQ, MGMT_IRQ,
         MGMT_RETURN, SCHED_HINT_EN, RST_N, PRIV_LEVEL, HIST_IDX} = 0;
        {REG_ADDR, REG_WDATA} = 0;
        BR_REC = 64'hABCD;
        TX_BEGIN_PC = 64'h1000;
        TX_FALLBACK_PC = 64'h2000;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        rd(12'h1D9, 64'h0);
        rd(12'h1DA, 64'h0);
        for (i = 0; i < 8; i = i + 1)
        begin
            d = {$random(seed), $random(seed)};
            wr(d);
            rd(12'h1D9, d & 64'hDFC7);
        end
        $display("register test done");
        // privilege filter: bit9 pass then bit10 pass
        for (k = 0; k < 2; k = k + 1)
        begin
            wr(k ? 64'h0444 : 64'h0244);
            for (i = 0; i < 6; i = i + 1)
            begin
                @(posedge CLK);
                PRIV_LEVEL <= (i > 2) ? 2'h3 : 2'h0;
                {BR_TAKEN, IRQ_TAKEN, EXC_TAKEN} <= 3'h1 << (i % 3);
                BUSLOCK_SEEN <= 1'b1;
                @(posedge CLK);
                {BR_TAKEN, IRQ_TAKEN, EXC_TAKEN, BUSLOCK_SEEN} <= 4'h0;
                @(negedge CLK);
                check(TRACE_MSG, (i > 2) ^ k[0]);
                check(BUSLOCK_EXC, i > 2);
            end
        end
        $display("trace filter test done");
        wr(64'h00C3);
        @(posedge CLK) DBG_EVENT <= 1'b1;
        @(posedge CLK) DBG_EVENT <= 1'b0;
        @(negedge CLK) check(DSTAT_TXDBG, 1'b1);
        rd(12'h1D9, 64'h00C0);
        $display("debug exception test done");
        // conflict, plain debug, then breakpoint with tx debug on
        for (i = 0; i < 3; i = i + 1)
        begin
            if (i == 2)
                wr(64'h8000);
            @(posedge CLK);
            IN_TX <= 1'b1;
            BPCTL_TXDBG <= (i == 2);
            {TX_CONFLICT, DBG_EVENT, BP_EVENT} <= 3'h4 >> i;
            @(posedge CLK);
            {TX_CONFLICT, DBG_EVENT, BP_EVENT} <= 3'h0;
            @(negedge CLK);
            check(TX_ABORT, 1'b1);
            check(ABORT_STATUS[4], i != 0);
            check(DBG_EXC, i == 2);
            check(TX_RESUME_PC, i == 2 ? TX_BEGIN_PC : TX_FALLBACK_PC);
        end
        check(DSTAT_TXDBG, 1'b0);
        $display("transaction test done");
        @(posedge CLK) SCHED_HINT_EN <= 1'b1;
        wr(64'h50C3);
        @(posedge CLK) MGMT_IRQ <= 1'b1;
        @(posedge CLK) MGMT_IRQ <= 1'b0;
        @(negedge CLK) check(CNT_GLOBAL_EN, 8'h00);
        check(SCHED_HIST_RST, 1'b1);
        rd(12'h1D9, 64'h5000);
        @(posedge CLK) PERF_IRQ <= 1'b1;
        @(posedge CLK) PERF_IRQ <= 1'b0;
        @(negedge CLK) check(CNT_FROZEN, 1'b1);
        @(posedge CLK) MGMT_RETURN <= 1'b1;
        @(posedge CLK) MGMT_RETURN <= 1'b0;
        @(negedge CLK) check(CNT_GLOBAL_EN, 8'hFF);
        check(SCHED_HIST_RST, 1'b1);
        rd(12'h1D9, 64'h50C3);
        check(PERF_CAP[12], 1'b1);
        $display("management test done");
        // fill history, store with buffer full toggling
        wr(64'h0981);
        for (i = 0; i < 8; i = i + 1)
        begin
            @(posedge CLK);
            {BR_TAKEN, BUF_FULL} <= {1'b1, i[0]};
            BR_REC <= 64'h5A5A;
            @(posedge CLK) BR_TAKEN <= 1'b0;
            @(negedge CLK);
            check(TRACE_STORE, !i[0]);
            check(TRACE_BUF_IRQ, i[0]);
            check(TRACE_MSG_DATA, 64'h5A5A);
        end
        @(posedge CLK) PERF_IRQ <= 1'b1;
        @(posedge CLK) PERF_IRQ <= 1'b0;
        @(posedge CLK);
        @(negedge CLK) check(HIST_FROZEN, 1'b1);
        // frozen: new branches must not displace the stored entries
        for (i = 0; i < 8; i = i + 1)
        begin
            @(posedge CLK);
            HIST_IDX <= i[2:0];
            BR_TAKEN <= 1'b1;
            BR_REC <= 64'h7777;
            @(posedge CLK) BR_TAKEN <= 1'b0;
            @(posedge CLK);
            @(negedge CLK) check(HIST_DATA, 64'h5A5A);
        end
        wr(64'h0080);
        @(posedge CLK) BR_TAKEN <= 1'b1;
        @(posedge CLK) BR_TAKEN <= 1'b0;
        @(negedge CLK);
        check(TRACE_WRAP, 1'b1);
        check(TRACE_STORE, 1'b1);
        // plain, branch, then plain again after the step-mode clear
        wr(64'h0002);
        for (i = 0; i < 3; i = i + 1)
        begin
            @(posedge CLK);
            {STEP_FLAG, INSTR_DONE, BR_TAKEN} <= {1'b1, 1'b1, i == 1};
            @(posedge CLK) {INSTR_DONE, BR_TAKEN} <= 2'h0;
            @(negedge CLK) check(STEP_TRAP, i != 0);
        end
        STEP_FLAG <= 1'b0;
        $display("trace store and step test done");
        repeat (2) @(posedge CLK);
        tally_and_finish;
    end
    // run needs about 150 cycles; a hang stops here
    initial
    begin
        repeat (3000) @(posedge CLK);
        bad_count = bad_count + 1;
        tally_and_finish;
    end
endmodule // test_debug_trace_control_logic
